// ==== verilog/asa_pkg.sv ====
// Shared constants and types for the serial adapter status and command block
`default_nettype none
package asa_pkg;
  // ********************************************************
  // Register addresses on the 8-bit processor bus
  // ********************************************************
  localparam logic [15:0] DATA_ADDR   = 16'hEFF0;
  localparam logic [15:0] STATUS_ADDR = 16'hEFF1;
  localparam logic [15:0] CMD_ADDR    = 16'hEFF2;
  localparam logic [15:0] CTRL_ADDR   = 16'hEFF3;

  // ********************************************************
  // Field positions and reset values
  // ********************************************************
  localparam int ST_PARITY  = 0;
  localparam int ST_FRAME   = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_RXFULL  = 3;
  localparam int ST_TXEMPTY = 4;
  localparam int ST_CARRIER = 5;
  localparam int ST_DSR     = 6;
  localparam int ST_IRQ     = 7;
  localparam int CMD_ENABLE = 0;
  localparam int CMD_RXBLK  = 1;
  localparam int CMD_TXM_LO = 2;
  localparam int CMD_ECHO   = 4;
  localparam int CMD_PAR_EN = 5;
  localparam int CMD_PSEL   = 6;
  localparam int CTRL_WL_LO = 0;
  localparam int CTRL_STOP2 = 2;
  localparam int CTRL_EXTCK = 3;
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEFAULT_BAUD  = 9600;
  localparam int NS_PER_S      = 1000000000;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] MID_SAMPLE      = 4'h7;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    TX_IRQ_OFF_CODE  = 2'h0,
    TX_IRQ_ON_CODE   = 2'h1,
    TX_IRQ_OFF_RTSLO = 2'h2,
    SEND_BREAK_CODE  = 2'h3
  } asa_txmode_t;
  typedef enum logic [1:0] {PAR_ODD = 2'h0, PAR_EVEN = 2'h1, PAR_MARK = 2'h2,
                            PAR_SPACE = 2'h3} asa_parsel_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h3,
                            RX_STOP = 2'h2} asa_rxstate_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} asa_txstate_t;
endpackage : asa_pkg
`default_nettype wire

// ==== verilog/asa_rx_shifter.sv ====
// Receive deserialiser: start detect, data and parity sampling, stop check
`timescale 1ns/1ns
`default_nettype none
module asa_rx_shifter (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Timing and line
  input  wire logic       tick16,
  input  wire logic       rxd,
  // Frame format
  input  wire logic       enable,
  input  wire logic [3:0] dataBits,
  input  wire logic       parPresent,
  input  wire logic       parCheck,
  input  wire logic       parOdd,
  // Received character
  output logic            charValid,
  output logic [7:0]      charData,
  output logic            parityErr,
  output logic            framingErr
);
  asa_pkg::asa_rxstate_t state_r, state_nxt;
  logic [3:0] sub_r;
  logic [3:0] idx_r;
  logic [8:0] sh_r;
  logic [3:0] total;
  logic [8:0] aligned;
  logic [7:0] dataMask;
  logic [7:0] dataWord;
  logic       parBit;
  logic       lastSub;

  // Bits to collect after the start bit, then right-justify them
  assign total    = dataBits + {3'h0, parPresent};
  assign aligned  = sh_r >> (4'd9 - total);
  assign dataMask = 8'(9'h0FF >> (4'd8 - dataBits));
  assign dataWord = aligned[7:0] & dataMask;
  assign parBit   = aligned[dataBits];
  assign lastSub  = tick16 && (sub_r == asa_pkg::OVERSAMPLE_LAST);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      asa_pkg::RX_IDLE:  if (enable && tick16 && !rxd) state_nxt = asa_pkg::RX_START;
      asa_pkg::RX_START: if (tick16 && sub_r == asa_pkg::MID_SAMPLE)
                           state_nxt = rxd ? asa_pkg::RX_IDLE : asa_pkg::RX_BITS;
      asa_pkg::RX_BITS:  if (lastSub && idx_r == total - 4'd1) state_nxt = asa_pkg::RX_STOP;
      asa_pkg::RX_STOP:  if (lastSub) state_nxt = asa_pkg::RX_IDLE;
      default:           state_nxt = asa_pkg::RX_IDLE;
    endcase
  end

  // Sampling counters and shift register, LSB arrives first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= asa_pkg::RX_IDLE;
      sub_r   <= 4'h0;
      idx_r   <= 4'h0;
      sh_r    <= 9'h000;
    end else begin
      state_r <= state_nxt;
      if (state_r != state_nxt) sub_r <= 4'h0;
      else if (tick16) sub_r <= sub_r + 4'h1;
      if (state_r == asa_pkg::RX_START) idx_r <= 4'h0;
      else if (state_r == asa_pkg::RX_BITS && lastSub) begin
        idx_r <= idx_r + 4'h1;
        sh_r  <= {rxd, sh_r[8:1]};
      end
    end
  end

  // Character delivery at the stop bit sample
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      charValid  <= 1'b0;
      charData   <= 8'h00;
      parityErr  <= 1'b0;
      framingErr <= 1'b0;
    end else begin
      charValid <= (state_r == asa_pkg::RX_STOP) && lastSub;
      if ((state_r == asa_pkg::RX_STOP) && lastSub) begin
        charData   <= dataWord;
        parityErr  <= parCheck && ((^dataWord ^ parBit) != parOdd);
        framingErr <= !rxd;
      end
    end
  end
endmodule : asa_rx_shifter
`default_nettype wire

// ==== verilog/asa_serial_adapter.sv ====
// Serial adapter: data, status, command and control registers with tx/rx
`timescale 1ns/1ns
`default_nettype none
module asa_serial_adapter #(
  parameter int BAUD = asa_pkg::DEFAULT_BAUD
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Processor bus
  input  wire logic [15:0] busAddr,
  input  wire logic        busRead,
  input  wire logic        busWrite,
  input  wire logic [7:0]  busWrData,
  output logic [7:0]       busRdData,
  output logic             irqN,
  // Serial line and modem controls
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        clearToSendN,
  output logic             requestToSendN,
  output logic             dataTermReadyN,
  input  wire logic        carrierDetectN,
  input  wire logic        dataSetReadyN,
  input  wire logic        extTick16
);
  localparam int DIV = asa_pkg::NS_PER_S / (asa_pkg::CLK_PERIOD_NS * 16 * BAUD);
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  // ********************************************************
  // Registers and wires
  // ********************************************************
  logic [7:0]  cmd_r, ctrl_r, rxData_r, txHold_r, status;
  logic        rxFull_r, txEmpty_r, overrun_r, parErr_r, frameErr_r, irq_r;
  logic [15:0] div_r;
  logic        intTick, tick16;
  logic        selData, selStatus, selCmd, selCtrl;
  logic        rdData, rdStatus, wrData;
  logic        enable, echo, parEn, parCheck, parOdd, stop2;
  logic [1:0]  parSel;
  logic [3:0]  dataBits, txTotal;
  asa_pkg::asa_txmode_t txMode;
  logic        charValid, rxParErr, rxFrameErr;
  logic [7:0]  charData, txMasked;
  logic        txParBit, txStart, txTransfer, irqSet;
  logic [11:0] txPayload;
  asa_pkg::asa_txstate_t txState_r;
  logic [11:0] txSh_r;
  logic [3:0]  txLeft_r, txSub_r;
  logic        txLast;

  // ********************************************************
  // Bus decode
  // ********************************************************
  assign selData   = busAddr == asa_pkg::DATA_ADDR;
  assign selStatus = busAddr == asa_pkg::STATUS_ADDR;
  assign selCmd    = busAddr == asa_pkg::CMD_ADDR;
  assign selCtrl   = busAddr == asa_pkg::CTRL_ADDR;
  assign rdData    = busRead && selData;
  assign rdStatus  = busRead && selStatus;
  assign wrData    = busWrite && selData;

  // Command and control field decode
  assign enable   = cmd_r[asa_pkg::CMD_ENABLE];
  assign txMode   = asa_pkg::asa_txmode_t'(cmd_r[asa_pkg::CMD_TXM_LO +: 2]);
  assign echo     = cmd_r[asa_pkg::CMD_ECHO];
  assign parEn    = cmd_r[asa_pkg::CMD_PAR_EN];
  assign parSel   = cmd_r[asa_pkg::CMD_PSEL +: 2];
  assign parCheck = parEn && !parSel[1];
  assign parOdd   = parSel == asa_pkg::PAR_ODD;
  assign dataBits = 4'd8 - {2'b00, ctrl_r[asa_pkg::CTRL_WL_LO +: 2]};
  assign stop2    = ctrl_r[asa_pkg::CTRL_STOP2];

  // Status assembly, modem bits taken straight from the pins
  assign status = {irq_r, dataSetReadyN, carrierDetectN, txEmpty_r,
                   rxFull_r, overrun_r, frameErr_r, parErr_r};

  // ********************************************************
  // Bit clock
  // ********************************************************
  assign intTick = div_r == DIV_LAST;
  assign tick16  = ctrl_r[asa_pkg::CTRL_EXTCK] ? extTick16 : intTick;

  // Internal sixteen-times divider
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) div_r <= 16'h0000;
    else div_r <= intTick ? 16'h0000 : div_r + 16'h0001;
  end

  // ********************************************************
  // Register file
  // ********************************************************
  // Writable registers; status address ignores writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_r    <= asa_pkg::CMD_RESET;
      ctrl_r   <= asa_pkg::CTRL_RESET;
      txHold_r <= asa_pkg::DATA_RESET;
    end else begin
      if (busWrite && selCmd) cmd_r <= busWrData;
      if (busWrite && selCtrl) ctrl_r <= busWrData;
      if (wrData) txHold_r <= busWrData;
    end
  end

  // Registered read data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) busRdData <= 8'h00;
    else if (busRead) begin
      case (1'b1)
        selData:   busRdData <= rxData_r;
        selStatus: busRdData <= status;
        selCmd:    busRdData <= cmd_r;
        selCtrl:   busRdData <= ctrl_r;
        default:   busRdData <= 8'h00;
      endcase
    end
  end

  // ********************************************************
  // Receive path and flags
  // ********************************************************
  asa_rx_shifter i_asa_rx_shifter (
    .clock      (clock),
    .resetn     (resetn),
    .tick16     (tick16),
    .rxd        (rxd),
    .enable     (enable),
    .dataBits   (dataBits),
    .parPresent (parEn),
    .parCheck   (parCheck),
    .parOdd     (parOdd),
    .charValid  (charValid),
    .charData   (charData),
    .parityErr  (rxParErr),
    .framingErr (rxFrameErr)
  );

  // Holding register and error flags; a new character wins over a read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rxData_r   <= asa_pkg::DATA_RESET;
      rxFull_r   <= 1'b0;
      overrun_r  <= 1'b0;
      parErr_r   <= 1'b0;
      frameErr_r <= 1'b0;
    end else if (charValid) begin
      overrun_r  <= rxFull_r && !rdData;
      if (!rxFull_r || rdData) begin
        rxData_r   <= charData;
        rxFull_r   <= 1'b1;
        parErr_r   <= rxParErr;
        frameErr_r <= rxFrameErr;
      end
    end else if (rdData) begin
      rxFull_r  <= 1'b0;
      overrun_r <= 1'b0;
    end
  end

  // ********************************************************
  // Transmit path
  // ********************************************************
  assign txMasked  = txHold_r & 8'(9'h0FF >> (4'd8 - dataBits));
  assign txParBit  = parSel[1] ? !parSel[0] : (^txMasked ^ parOdd);
  assign txPayload = (12'hFFF << (dataBits + {3'h0, parEn}))
                   | ({11'h000, txParBit & parEn} << dataBits)
                   | {4'h0, txMasked};
  assign txTotal   = 4'd2 + dataBits + {3'h0, parEn} + {3'h0, stop2};
  assign txStart   = txState_r == asa_pkg::TX_IDLE && !txEmpty_r && enable
                   && !clearToSendN && txMode != asa_pkg::SEND_BREAK_CODE;
  assign txTransfer = txStart;
  assign txLast    = tick16 && txSub_r == asa_pkg::OVERSAMPLE_LAST;

  // Shifter: start bit, data LSB first, parity, stop bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txState_r <= asa_pkg::TX_IDLE;
      txSh_r    <= 12'hFFF;
      txLeft_r  <= 4'h0;
      txSub_r   <= 4'h0;
    end else begin
      case (txState_r)
        asa_pkg::TX_IDLE: if (txStart) begin
          txSh_r    <= {txPayload[10:0], 1'b0};
          txLeft_r  <= txTotal;
          txSub_r   <= 4'h0;
          txState_r <= asa_pkg::TX_SHIFT;
        end
        asa_pkg::TX_SHIFT: begin
          if (tick16) txSub_r <= txSub_r + 4'h1;
          if (txLast) begin
            txSh_r   <= {1'b1, txSh_r[11:1]};
            txLeft_r <= txLeft_r - 4'h1;
            if (txLeft_r == 4'h1) txState_r <= asa_pkg::TX_IDLE;
          end
        end
        default: txState_r <= asa_pkg::TX_IDLE;
      endcase
    end
  end

  // Holding flag: the transfer sets it, a data write clears it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) txEmpty_r <= 1'b1;
    else if (txTransfer) txEmpty_r <= 1'b1;
    else if (wrData) txEmpty_r <= 1'b0;
  end

  // Line and modem outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txd            <= 1'b1;
      requestToSendN <= 1'b1;
      dataTermReadyN <= 1'b1;
    end else begin
      if (echo) txd <= rxd;
      else if (txState_r == asa_pkg::TX_SHIFT) txd <= txSh_r[0];
      else txd <= txMode != asa_pkg::SEND_BREAK_CODE;
      requestToSendN <= txMode == asa_pkg::TX_IRQ_OFF_CODE;
      dataTermReadyN <= !enable;
    end
  end

  // ********************************************************
  // Interrupt flag
  // ********************************************************
  assign irqSet = (charValid && !cmd_r[asa_pkg::CMD_RXBLK])
               || (txTransfer && txMode == asa_pkg::TX_IRQ_ON_CODE);

  // A new event wins over the clearing status read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) irq_r <= 1'b0;
    else if (irqSet) irq_r <= 1'b1;
    else if (rdStatus) irq_r <= 1'b0;
  end
  assign irqN = !irq_r;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  status_ro_a: assert property (busWrite && selStatus && !charValid && !rdData
    |=> $stable(rxFull_r) && $stable(parErr_r)) else $error("status write changed flags");
  irq_clear_a: assert property (rdStatus && !irqSet |=> !irq_r)
    else $error("status read left interrupt flag set");
  irq_rx_a: assert property (charValid && cmd_r[asa_pkg::CMD_RXBLK]
    && !txTransfer && !irq_r |=> !irq_r) else $error("blocked receive raised interrupt");
  pins_status_a: assert property (rdStatus |=> busRdData[asa_pkg::ST_CARRIER]
    == $past(carrierDetectN) && busRdData[asa_pkg::ST_DSR] == $past(dataSetReadyN))
    else $error("modem status bits do not follow pins");
  dtr_enable_a: assert property (busWrite && selCmd |-> ##2
    dataTermReadyN == !$past(busWrData[asa_pkg::CMD_ENABLE], 2))
    else $error("DTR does not follow enable bit");
  rts_mode_a: assert property (##1 requestToSendN ==
    ($past(txMode) == asa_pkg::TX_IRQ_OFF_CODE)) else $error("RTS wrong for mode");
  break_line_a: assert property ((txMode == asa_pkg::SEND_BREAK_CODE
    && txState_r == asa_pkg::TX_IDLE && !echo)[*2] |-> !txd) else $error("break not sent");
  cts_hold_a: assert property (clearToSendN && txState_r == asa_pkg::TX_IDLE
    |=> txState_r == asa_pkg::TX_IDLE) else $error("transmit started without CTS");
  rx_clear_a: assert property (rdData && !charValid |=> !rxFull_r)
    else $error("data read left receive full set");
  tx_fill_a: assert property (wrData && !txTransfer |=> !txEmpty_r)
    else $error("data write left transmit empty set");
  tx_load_a: assert property (txStart |=> txEmpty_r
    && txState_r == asa_pkg::TX_SHIFT) else $error("transfer left holding flag clear");
  rx_load_a: assert property (charValid && !rxFull_r |=> rxFull_r)
    else $error("received character did not set full flag");

  rx_char_c: cover property (charValid ##1 rxFull_r);
  tx_frame_c: cover property (txStart ##[1:1000] txState_r == asa_pkg::TX_IDLE);
  break_c: cover property (txMode == asa_pkg::SEND_BREAK_CODE && !txd);
  overrun_c: cover property (overrun_r);
endmodule : asa_serial_adapter
`default_nettype wire

// ==== bench/asa_line_model.sv ====
// Far-side line model: sends frames on rxd and captures frames from txd
`timescale 1ns/1ns
`default_nettype none
module asa_line_model (
  // Clock
  input  wire logic       clock,
  // Serial line
  input  wire logic       txd,
  output logic            rxd,
  // Capture length and result
  input  wire logic [3:0] capLen,
  output logic [9:0]      capData,
  output logic            capDone
);
  // ****************
  // Line driver
  // ****************
  initial begin
    rxd = 1'b1;
    capDone = 1'b0;
    capData = '0;
  end
  // Shift a frame out LSB first, 16 clocks per bit, then idle at mark
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = f[i];
      repeat (16) @(posedge clock);
      #1;
    end
    rxd = 1'b1;
  endtask : send
  // ****************
  // Line capture
  // ****************
  // Samples mid-bit after each start edge; zero length ignores the line
  initial begin : capture
    forever begin
      @(negedge txd);
      repeat (8) @(posedge clock);
      capData <= '0;
      for (int i = 0; i < capLen; i++) begin
        repeat (16) @(posedge clock);
        capData[i] <= txd;
      end
      if (capLen != 4'h0) begin
        capDone <= 1'b1;
        @(posedge clock);
        capDone <= 1'b0;
      end
    end
  end
endmodule : asa_line_model
`default_nettype wire

// ==== bench/tb_asa_serial_adapter.sv ====
// Testbench for the serial adapter status and command block
`timescale 1ns/1ns
`default_nettype none
module tb_asa_serial_adapter;
  // ****************
  // Signals
  // ****************
  localparam logic [15:0] DA = asa_pkg::DATA_ADDR;
  localparam logic [15:0] SA = asa_pkg::STATUS_ADDR;
  localparam logic [15:0] CA = asa_pkg::CMD_ADDR;
  localparam logic [15:0] TA = asa_pkg::CTRL_ADDR;
  logic        clock, resetn, busRead, busWrite, irqN, rxd, txd, rdLate;
  logic        ctsN, rtsN, dtrN, dcdN, dsrN, capDone, ext16;
  logic [15:0] busAddr;
  logic [7:0]  busWrData, busRdData;
  logic [3:0]  capLen;
  logic [9:0]  capData;
  logic [7:0]  rdQ[$];
  logic [9:0]  frQ[$];
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed;

  asa_serial_adapter i_asa_serial_adapter (
    .clock(clock), .resetn(resetn), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busWrData(busWrData), .busRdData(busRdData), .irqN(irqN),
    .rxd(rxd), .txd(txd), .clearToSendN(ctsN), .requestToSendN(rtsN),
    .dataTermReadyN(dtrN), .carrierDetectN(dcdN), .dataSetReadyN(dsrN),
    .extTick16(ext16)
  );
  asa_line_model i_asa_line_model (
    .clock(clock), .txd(txd), .rxd(rxd), .capLen(capLen), .capData(capData),
    .capDone(capDone)
  );

  // ****************
  // Tasks
  // ****************
  task automatic stop_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic cmpB(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmpB
  task automatic cmpF(input logic [9:0] g, input logic [9:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t frame got=%h exp=%h", $time, g, e);
    end
  endtask : cmpF
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // Bus write, then one idle edge before the next strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    busAddr = a;
    busWrData = d;
    busWrite = 1'b1;
    cyc(1);
    busWrite = 1'b0;
    cyc(1);
  endtask : wr
  // Bus read; the expected byte is queued for the read watcher
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    busAddr = a;
    busRead = 1'b1;
    rdQ.push_back(e);
    cyc(1);
    busRead = 1'b0;
    cyc(1);
  endtask : rd
  // Far side sends start, 8 data, odd parity (optionally wrong), stop
  task automatic rxf(input logic [7:0] d, input logic bad, input logic stp);
    i_asa_line_model.send({1'b0, stp, ~^d ^ bad, d, 1'b0}, 11);
    cyc(20);
  endtask : rxf
  // Status from flags {irq, txe, full, ov, fe, pe} and the modem pins
  function automatic logic [7:0] st(input logic [5:0] f);
    st = {f[5], dsrN, dcdN, f[4:0]};
  endfunction : st

  // ****************
  // Watchers
  // ****************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Read data is settled half a cycle after the taking edge
  always @(posedge clock) rdLate <= busRead;
  always @(negedge clock) begin
    if (rdLate) begin
      cmpB(busRdData, rdQ.pop_front());
    end
  end
  // Every captured frame must have been announced
  always @(posedge clock) begin
    if (capDone) begin
      cmpF(capData, (frQ.size() != 0) ? frQ.pop_front() : 10'bx);
    end
  end
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin : main
    logic [7:0] d;
    logic [7:0] e;
    logic       pb;
    seed = 32'hAA21;
    resetn = 1'b0;
    {busAddr, busRead, busWrite, busWrData} = '0;
    {ctsN, dcdN, dsrN} = 3'h3;
    ext16 = 1'b1;
    capLen = 4'h0;
    repeat (5) @(posedge clock);
    #1;
    resetn = 1'b1;
    cmpB({6'h0, dtrN, rtsN}, 8'h03);
    for (int i = 0; i < 4; i++) begin
      {dsrN, dcdN} = i[1:0];
      cyc(2);
      rd(SA, st(6'h10));
    end
    wr(SA, 8'hFF);
    rd(SA, st(6'h10));
    // Transmit modes: readback, RTS and break level
    for (int m = 0; m < 4; m++) begin
      e = {4'h0, m[1:0], 2'h1};
      wr(CA, e);
      cyc(2);
      rd(CA, e);
      cmpB({6'h0, rtsN, txd}, {6'h0, m == 0, m != 3});
      cmpB({7'h0, dtrN}, 8'h00);
    end
    wr(CA, 8'h00);
    cyc(2);
    cmpB({6'h0, dtrN, txd}, 8'h03);
    wr(TA, 8'h08);
    rd(TA, 8'h08);
    // Parity kinds on transmit, last pass with seven data bits and two stops
    for (int p = 0; p < 5; p++) begin
      d = 8'($random(seed));
      pb = (p == 0) ? ~^d : (p == 1) ? ^d : (p == 2);
      if (p == 4) begin
        wr(TA, 8'h0D);
      end
      wr(CA, {p[1:0], p < 4, 5'h05});
      capLen = (p < 4) ? 4'hA : 4'h9;
      frQ.push_back((p < 4) ? {1'b1, pb, d} : {3'h3, d[6:0]});
      wr(DA, d);
      cyc(4);
      cmpB({7'h0, irqN}, 8'h00);
      rd(SA, st(6'h30));
      rd(SA, st(6'h10));
      while (frQ.size() != 0) cyc(1);
    end
    // Clear-to-send high holds the byte back
    wr(TA, 8'h08);
    capLen = 4'h9;
    ctsN = 1'b1;
    d = 8'($random(seed));
    frQ.push_back({2'h1, d});
    wr(DA, d);
    cyc(40);
    rd(SA, st(6'h00));
    cmpB({7'h0, txd}, 8'h01);
    ctsN = 1'b0;
    while (frQ.size() != 0) cyc(1);
    rd(SA, st(6'h30));
    // Receive: full, parity, framing, overrun, blocked interrupt
    wr(CA, 8'h29);
    d = 8'($random(seed));
    rxf(d, 1'b0, 1'b1);
    rd(SA, st(6'h38));
    rd(DA, d);
    rd(SA, st(6'h10));
    rxf(d, 1'b1, 1'b1);
    rd(SA, st(6'h39));
    rd(DA, d);
    rxf(d, 1'b0, 1'b0);
    rd(SA, st(6'h3A));
    rd(DA, d);
    wr(CA, 8'hA9);
    rxf(d, 1'b1, 1'b1);
    rd(SA, st(6'h38));
    rd(DA, d);
    wr(CA, 8'h2B);
    rxf(d, 1'b0, 1'b1);
    e = 8'($random(seed));
    rxf(e, 1'b0, 1'b1);
    rd(SA, st(6'h1C));
    rd(DA, d);
    rd(SA, st(6'h10));
    // Echo retransmits the received frame; disabled receiver ignores the line
    wr(CA, 8'h39);
    capLen = 4'hA;
    frQ.push_back({1'b1, ~^d, d});
    rxf(d, 1'b0, 1'b1);
    while (frQ.size() != 0) cyc(1);
    rd(DA, d);
    rd(SA, st(6'h30));
    wr(CA, 8'h28);
    rxf(d, 1'b0, 1'b1);
    rd(SA, st(6'h10));
    // Internal divider selected: the always-on external tick must be ignored
    wr(TA, 8'h00);
    wr(CA, 8'h29);
    rxf(d, 1'b0, 1'b1);
    rd(SA, st(6'h10));
    stop_test();
  end
endmodule : tb_asa_serial_adapter
`default_nettype wire
